// file: rtl/sfr_regs.vh
// Purpose: shared constants for the synchronous fifo with reset and flag control
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only, guarded against double inclusion
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// data path and memory geometry
`define SFR_DW        36
`define SFR_AW        10
`define SFR_PW        11
`define SFR_DEPTH     11'h400

// port b width select codes
`define SFR_WS_36     2'h0
`define SFR_WS_18     2'h1
`define SFR_WS_9      2'h2

// default almost flag offsets, chosen by the two offset selects
`define SFR_FS_8      2'h1
`define SFR_FS_16     2'h2
`define SFR_FS_64     2'h3
`define SFR_OFS_8     10'h008
`define SFR_OFS_16    10'h010
`define SFR_OFS_64    10'h040
`define SFR_OFS_RST   10'h008

// serial offset load: 20 bits, y first then x
`define SFR_SER_LAST  5'h13

// parallel offset load: two port a writes
`define SFR_PAR_LAST  5'h01

// reset value of the mailboxes and data output registers
`define SFR_MAIL_RST  36'h000000000

`endif

// file: rtl/sfr_sync.v
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: each bit is a level that is static or slow against the clock
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps

module sfr_sync #(
    parameter W = 10
) (
    input  wire         clock,    // system clock
    input  wire         sys_rst,  // synchronous reset, active high
    input  wire [W-1:0] pin_in,   // raw pin levels
    output wire [W-1:0] pin_out   // synchronised levels
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage feeds only the second stage
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    assign pin_out = sync_r;

endmodule

// file: rtl/sfr_mem.v
// Purpose: fifo storage, one write port and one registered read port
// Assumes: read data is one clock behind the read address
// Notes:   read during write at one address returns the old word
`timescale 1ns/1ps
`include "sfr_regs.vh"

module sfr_mem (
    input  wire                clock,    // system clock
    input  wire                wr_en,    // write strobe
    input  wire [`SFR_AW-1:0]  wr_addr,  // write address
    input  wire [`SFR_DW-1:0]  wr_data,  // write word
    input  wire [`SFR_AW-1:0]  rd_addr,  // read address
    output wire [`SFR_DW-1:0]  rd_data   // registered read word
);

    reg [`SFR_DW-1:0] ram [0:(1<<`SFR_AW)-1];
    reg [`SFR_DW-1:0] rd_data_r;

    // storage has no reset, pointers alone define contents
    always @(posedge clock) begin
        if (wr_en) begin
            ram[wr_addr] <= wr_data;
        end
        rd_data_r <= ram[rd_addr];
    end

    assign rd_data = rd_data_r;

endmodule

// file: rtl/sfr_top.v
// Purpose: unidirectional fifo with mailboxes, flags, resets, bus matching
// Assumes: both ports run on the one system clock; reset and mode pins are synchronised
// Notes:   reset and mode pins see two flops of latency before acting
`timescale 1ns/1ps
`include "sfr_regs.vh"

module sfr_top (
    input  wire               clock,                  // 20 MHz clock
    input  wire               sys_rst,                // sync reset, high
    input  wire               master_reset_first_n,   // master reset pin, low
    input  wire               master_reset_second_n,  // mail two reset pin, low
    input  wire               partial_flush_n,        // partial reset pin, low
    input  wire               endian_timing_select,   // endian / timing pin
    input  wire               offset_select_lo,       // offset select bit 0
    input  wire               offset_select_hi,       // offset select bit 1
    input  wire               serial_program_select,  // low selects serial load
    input  wire               serial_offset_in,       // serial offset data
    input  wire [1:0]         port_b_width_sel,       // port b width code
    input  wire               port_a_select_n,        // port a chip select
    input  wire               port_a_direction,       // high write, low read
    input  wire               port_a_enable,          // port a enable
    input  wire               port_a_mail_select,     // port a mailbox select
    input  wire [`SFR_DW-1:0] port_a_data_in,         // port a bus in
    output wire [`SFR_DW-1:0] port_a_data_out,        // port a bus out
    output wire               port_a_data_oe,         // port a drive enable
    input  wire               port_b_select_n,        // port b chip select
    input  wire               port_b_direction,       // high read, low write
    input  wire               port_b_enable,          // port b enable
    input  wire               port_b_mail_select,     // port b mailbox select
    input  wire [`SFR_DW-1:0] port_b_data_in,         // port b bus in
    output wire [`SFR_DW-1:0] port_b_data_out,        // port b bus out
    output wire               port_b_data_oe,         // port b drive enable
    output wire               full_or_in_ready,       // full flag / in ready
    output wire               empty_or_out_ready,     // empty flag / out ready
    output wire               almost_empty_n,         // almost empty, low
    output wire               almost_full_n,          // almost full, low
    output wire               mail_one_flag,          // mail one empty, high
    output wire               mail_two_flag           // mail two empty, high
);

    localparam ST_RST   = 5'b00001;
    localparam ST_WAIT  = 5'b00010;
    localparam ST_PPROG = 5'b00100;
    localparam ST_SPROG = 5'b01000;
    localparam ST_RUN   = 5'b10000;

    // last piece index for the selected port b width
    function [1:0] last_piece;
        input [1:0] ws;
        begin
            case (ws)
                `SFR_WS_18: last_piece = 2'h1;
                `SFR_WS_9:  last_piece = 2'h3;
                default:    last_piece = 2'h0;
            endcase
        end
    endfunction

    // clear bits above the selected port b width
    function [`SFR_DW-1:0] width_mask;
        input [`SFR_DW-1:0] w;
        input [1:0]         ws;
        begin
            case (ws)
                `SFR_WS_18: width_mask = {18'h00000, w[17:0]};
                `SFR_WS_9:  width_mask = {27'h0000000, w[8:0]};
                default:    width_mask = w;
            endcase
        end
    endfunction

    // pick one piece of a long word in endian order
    function [`SFR_DW-1:0] piece;
        input [`SFR_DW-1:0] w;
        input [1:0]         idx;
        input [1:0]         ws;
        input               big;
        reg   [1:0]         s;
        begin
            s = big ? (last_piece(ws) - idx) : idx;
            case (ws)
                `SFR_WS_18: piece = {18'h00000, s[0] ? w[35:18] : w[17:0]};
                `SFR_WS_9: begin
                    case (s)
                        2'h0:    piece = {27'h0000000, w[8:0]};
                        2'h1:    piece = {27'h0000000, w[17:9]};
                        2'h2:    piece = {27'h0000000, w[26:18]};
                        default: piece = {27'h0000000, w[35:27]};
                    endcase
                end
                default:    piece = w;
            endcase
        end
    endfunction

    // default offset for a pair of offset selects
    function [`SFR_AW-1:0] default_ofs;
        input [1:0] fs;
        begin
            case (fs)
                `SFR_FS_8:  default_ofs = `SFR_OFS_8;
                `SFR_FS_16: default_ofs = `SFR_OFS_16;
                `SFR_FS_64: default_ofs = `SFR_OFS_64;
                default:    default_ofs = `SFR_OFS_RST;
            endcase
        end
    endfunction

    wire [9:0]         pin_s;
    wire [`SFR_DW-1:0] mem_rd;
    reg                mrs_d_r;
    reg                big_end_r;
    reg  [1:0]         wsel_r;
    reg                spm_r;
    reg  [1:0]         fs_r;
    reg                fall_r;
    reg                need_prog_r;
    reg  [`SFR_AW-1:0] x_ofs_r;
    reg  [`SFR_AW-1:0] y_ofs_r;
    reg  [4:0]         state_r;
    reg  [4:0]         state_nxt;
    reg  [4:0]         prog_cnt_r;
    reg  [`SFR_PW-1:0] wptr_r;
    reg  [`SFR_PW-1:0] wvis_r;
    reg  [`SFR_PW-1:0] rptr_r;
    reg  [1:0]         pc_r;
    reg  [`SFR_DW-1:0] hold_r;
    reg                out_valid_r;
    reg  [`SFR_DW-1:0] b_out_r;
    reg                b_oe_r;
    reg  [`SFR_DW-1:0] a_out_r;
    reg                a_oe_r;
    reg                in_rdy_r;
    reg                out_rdy_r;
    reg                ae_n_r;
    reg                af_n_r;
    reg  [`SFR_DW-1:0] mail_one_r;
    reg  [`SFR_DW-1:0] mail_two_r;
    reg                mail_one_flag_r;
    reg                mail_two_flag_r;

    // all reset and mode pins are async, so bring them in together
    sfr_sync #(
        .W (10)
    ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  ({port_b_width_sel, serial_offset_in, serial_program_select,
                   offset_select_hi, offset_select_lo, endian_timing_select,
                   partial_flush_n, master_reset_second_n, master_reset_first_n}),
        .pin_out (pin_s)
    );

    wire       mrs_s    = pin_s[0];
    wire       master_reset_second_s   = pin_s[1];
    wire       prs_s    = pin_s[2];
    wire       ets_s    = pin_s[3];
    wire [1:0] fsel_s   = pin_s[5:4];
    wire       spm_s    = pin_s[6];
    wire       ser_s    = pin_s[7];
    wire [1:0] wsel_s   = pin_s[9:8];
    wire       core_rst = sys_rst | ~mrs_s | ~prs_s;
    wire       mrs_rise = mrs_s & ~mrs_d_r;

    // request decode for both ports
    wire a_wr_go  = ~port_a_select_n & port_a_direction & port_a_enable
                    & ~port_a_mail_select & in_rdy_r;
    wire fifo_wr  = a_wr_go & state_r[4];
    wire a_mb_wr  = ~port_a_select_n & port_a_direction & port_a_enable
                    & port_a_mail_select & mail_one_flag_r;
    wire a_mb_rd  = ~port_a_select_n & ~port_a_direction & port_a_enable
                    & port_a_mail_select;
    wire b_rd_go  = ~port_b_select_n & port_b_direction & port_b_enable
                    & ~port_b_mail_select & out_rdy_r;
    wire b_mb_rd  = ~port_b_select_n & port_b_direction & port_b_enable
                    & port_b_mail_select;
    wire b_mb_wr  = ~port_b_select_n & ~port_b_direction & port_b_enable
                    & port_b_mail_select & mail_two_flag_r;
    wire ser_go   = state_r[3] & ~fsel_s[1];
    wire par_go   = state_r[2] & a_wr_go;

    // post-release sequencing: ready comes two edges after release, or with the 20th bit of a serial load
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RST: state_nxt = ST_WAIT;
            ST_WAIT: begin
                if (need_prog_r & ~spm_r) begin
                    state_nxt = ST_SPROG;
                end else if (need_prog_r & (fs_r == 2'h0)) begin
                    state_nxt = ST_PPROG;
                end else begin
                    state_nxt = ST_RUN;
                end
            end
            ST_PPROG: begin
                if (par_go & (prog_cnt_r == `SFR_PAR_LAST)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SPROG: begin
                if (ser_go & (prog_cnt_r == `SFR_SER_LAST)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: state_nxt = ST_RUN;
            default: state_nxt = ST_RST;
        endcase
        if (core_rst) begin
            state_nxt = ST_RST;
        end
    end

    // read side advance: one piece, popping memory at piece zero
    wire [1:0]         plast   = last_piece(wsel_r);
    wire               avail   = (wvis_r != rptr_r) | (pc_r != 2'h0);
    wire               adv_std = b_rd_go & avail;
    wire               adv_ft  = (~out_valid_r | b_rd_go) & avail & ~b_mb_rd;
    wire               adv     = fall_r ? adv_ft : adv_std;
    wire               pop     = adv & (pc_r == 2'h0);
    wire [1:0]         pc_nxt  = ~adv ? pc_r : ((pc_r == plast) ? 2'h0 : pc_r + 2'h1);
    wire [`SFR_PW-1:0] rptr_nxt = rptr_r + {{(`SFR_PW-1){1'b0}}, pop};
    wire [`SFR_PW-1:0] wptr_nxt = wptr_r + {{(`SFR_PW-1){1'b0}}, fifo_wr};
    wire               ov_nxt   = adv | (out_valid_r & ~b_rd_go);
    wire               av_nxt   = (wptr_r != rptr_nxt) | (pc_nxt != 2'h0);
    wire [`SFR_PW-1:0] words_rd = wptr_r - rptr_nxt;
    wire [`SFR_PW-1:0] used_wr  = wptr_nxt - rptr_nxt;
    wire [`SFR_PW-1:0] free_wr  = `SFR_DEPTH - used_wr;
    wire [`SFR_DW-1:0] src_word = (pc_r == 2'h0) ? mem_rd : hold_r;
    wire               wr_open  = state_nxt[4] | state_nxt[2];

    sfr_mem u_mem (
        .clock   (clock),
        .wr_en   (fifo_wr),
        .wr_addr (wptr_r[`SFR_AW-1:0]),
        .wr_data (port_a_data_in),
        .rd_addr (rptr_nxt[`SFR_AW-1:0]),
        .rd_data (mem_rd)
    );

    // configuration: caught at master release, kept over partial reset
    always @(posedge clock) begin
        if (sys_rst) begin
            mrs_d_r     <= 1'b0;
            big_end_r   <= 1'b0;
            wsel_r      <= `SFR_WS_36;
            spm_r       <= 1'b1;
            fs_r        <= `SFR_FS_8;
            fall_r      <= 1'b0;
            need_prog_r <= 1'b0;
            x_ofs_r     <= `SFR_OFS_RST;
            y_ofs_r     <= `SFR_OFS_RST;
        end else begin
            mrs_d_r <= mrs_s;
            if (mrs_rise) begin
                big_end_r   <= ets_s;
                wsel_r      <= wsel_s;
                spm_r       <= spm_s;
                fs_r        <= fsel_s;
                need_prog_r <= 1'b1;
                if (spm_s & (fsel_s != 2'h0)) begin
                    x_ofs_r <= default_ofs(fsel_s);
                    y_ofs_r <= default_ofs(fsel_s);
                end
            end
            // sampled on the second edge after release
            if (state_r[1] & need_prog_r) begin
                fall_r <= ~ets_s;
            end
            if (state_nxt[4]) begin
                need_prog_r <= 1'b0;
            end
            // y then x, msb of y first
            if (ser_go) begin
                {y_ofs_r, x_ofs_r} <= {y_ofs_r[`SFR_AW-2:0], x_ofs_r, ser_s};
            end
            if (par_go & (prog_cnt_r == 5'h00)) begin
                y_ofs_r <= port_a_data_in[`SFR_AW-1:0];
            end
            if (par_go & (prog_cnt_r != 5'h00)) begin
                x_ofs_r <= port_a_data_in[`SFR_AW-1:0];
            end
        end
    end

    // fifo pointers, output register and flags
    always @(posedge clock) begin
        if (core_rst) begin
            state_r     <= ST_RST;
            prog_cnt_r  <= 5'h00;
            wptr_r      <= {`SFR_PW{1'b0}};
            wvis_r      <= {`SFR_PW{1'b0}};
            rptr_r      <= {`SFR_PW{1'b0}};
            pc_r        <= 2'h0;
            hold_r      <= `SFR_MAIL_RST;
            out_valid_r <= 1'b0;
            b_out_r     <= `SFR_MAIL_RST;
            in_rdy_r    <= 1'b0;
            out_rdy_r   <= 1'b0;
            ae_n_r      <= 1'b0;
            af_n_r      <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (ser_go | par_go) begin
                prog_cnt_r <= prog_cnt_r + 5'h01;
            end
            wptr_r <= wptr_nxt;
            wvis_r <= wptr_r;                 // memory is readable one cycle on
            rptr_r <= rptr_nxt;
            pc_r   <= pc_nxt;
            if (pop) begin
                hold_r <= mem_rd;
            end
            out_valid_r <= ov_nxt;
            // mailbox read takes the output register over the fifo
            if (b_mb_rd) begin
                b_out_r <= width_mask(mail_one_r, wsel_r);
            end else if (adv) begin
                b_out_r <= piece(src_word, pc_r, wsel_r, big_end_r);
            end
            // write side flags: ready high on the second edge after release, or with the 20th bit of a serial load; almost full high from reset
            in_rdy_r <= wr_open & (used_wr != `SFR_DEPTH);
            af_n_r   <= free_wr > {1'b0, y_ofs_r};
            // read side flags
            out_rdy_r <= state_r[4] & (fall_r ? ov_nxt : av_nxt);
            ae_n_r    <= words_rd > {1'b0, x_ofs_r};
        end
    end

    // mailboxes: new mail wins over a read in the same cycle
    always @(posedge clock) begin
        if (sys_rst) begin
            mail_one_r <= `SFR_MAIL_RST;
        end else if (a_mb_wr) begin
            mail_one_r <= width_mask(port_a_data_in, wsel_r);
        end
        if (sys_rst | ~master_reset_second_s) begin
            mail_two_r <= `SFR_MAIL_RST;
        end else if (b_mb_wr) begin
            mail_two_r <= width_mask(port_b_data_in, wsel_r);
        end
        if (core_rst) begin
            mail_one_flag_r <= 1'b1;
        end else if (a_mb_wr) begin
            mail_one_flag_r <= 1'b0;
        end else if (b_mb_rd) begin
            mail_one_flag_r <= 1'b1;
        end
        if (core_rst | ~master_reset_second_s) begin
            mail_two_flag_r <= 1'b1;
        end else if (b_mb_wr) begin
            mail_two_flag_r <= 1'b0;
        end else if (a_mb_rd) begin
            mail_two_flag_r <= 1'b1;
        end
    end

    // bus drivers follow select and direction one cycle late
    always @(posedge clock) begin
        if (sys_rst) begin
            a_out_r <= `SFR_MAIL_RST;
            a_oe_r  <= 1'b0;
            b_oe_r  <= 1'b0;
        end else begin
            if (a_mb_rd) begin
                a_out_r <= mail_two_r;
            end
            a_oe_r <= ~port_a_select_n & ~port_a_direction;
            b_oe_r <= ~port_b_select_n & port_b_direction;
        end
    end

    assign port_a_data_out    = a_out_r;
    assign port_a_data_oe     = a_oe_r;
    assign port_b_data_out    = b_out_r;
    assign port_b_data_oe     = b_oe_r;
    assign full_or_in_ready   = in_rdy_r;
    assign empty_or_out_ready = out_rdy_r;
    assign almost_empty_n     = ae_n_r;
    assign almost_full_n      = af_n_r;
    assign mail_one_flag      = mail_one_flag_r;
    assign mail_two_flag      = mail_two_flag_r;

endmodule

// file: tb/sfr_assertions.sv
// Purpose: concurrent checks on the fifo flags, mailboxes and reset behaviour
// Assumes: one clock for both ports; reset pins pass two sync flops in the design
// Notes:   antecedents wait for the pins to stay low, since the synced reset lags them
`timescale 1ns/1ps

// ports are grouped several to a line to keep the checker short
module sfr_chk (
    input wire        clock, sys_rst, master_reset_first_n, partial_flush_n, // clock, resets
    input wire        serial_program_select,                               // offset load mode
    input wire        port_a_select_n, port_a_direction, port_a_enable,   // port a controls
    input wire        port_a_mail_select, port_b_mail_select,             // mailbox selects
    input wire        port_b_select_n, port_b_direction, port_b_enable,   // port b controls
    input wire [35:0] port_b_data_out,                                    // port b bus out
    input wire        full_or_in_ready, empty_or_out_ready,               // main flags
    input wire        almost_empty_n, almost_full_n, mail_one_flag, mail_two_flag // others
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // decoded port operations, qualified only while both reset pins are high
    wire run  = master_reset_first_n & partial_flush_n;
    wire am_w = ~port_a_select_n & port_a_direction & port_a_enable & port_a_mail_select;
    wire bm   = ~port_b_select_n & port_b_enable & port_b_mail_select;

    a_master_flags: assert property (!master_reset_first_n [*4] |-> !full_or_in_ready
        && !empty_or_out_ready && !almost_empty_n && almost_full_n && mail_one_flag
        && mail_two_flag && port_b_data_out == 36'h0) else $error("master reset flags wrong");
    a_flush_flags: assert property (!partial_flush_n [*4] |-> !full_or_in_ready
        && !empty_or_out_ready && !almost_empty_n && almost_full_n && mail_one_flag
        && mail_two_flag) else $error("partial reset flags wrong");
    a_master_ready: assert property ($rose(master_reset_first_n) && partial_flush_n
        && serial_program_select |-> ##[1:6] full_or_in_ready) else $error("no ready after reset");
    a_flush_ready: assert property ($rose(partial_flush_n) && master_reset_first_n
        |-> ##[1:6] full_or_in_ready) else $error("no ready after flush");
    a_mail_one_set: assert property (am_w && mail_one_flag && full_or_in_ready && run
        |=> !mail_one_flag) else $error("mail one flag not lowered");
    a_mail_one_clr: assert property (bm && port_b_direction && !am_w && run
        |=> mail_one_flag) else $error("mail one flag not raised");
    a_mail_two_set: assert property (bm && !port_b_direction && mail_two_flag && run
        && full_or_in_ready |=> !mail_two_flag) else $error("mail two flag not lowered");
    a_empty_low: assert property (full_or_in_ready && !empty_or_out_ready
        |-> !almost_empty_n) else $error("almost empty high while empty");
    a_full_low: assert property (!full_or_in_ready && empty_or_out_ready
        |-> !almost_full_n) else $error("almost full high while full");
    // main scenarios reached
    c_full: cover property (!full_or_in_ready && empty_or_out_ready);
    c_af: cover property ($fell(almost_full_n));
    c_or: cover property ($rose(empty_or_out_ready));
endmodule

bind sfr_top sfr_chk chk_u (.clock, .sys_rst, .master_reset_first_n, .partial_flush_n,
    .serial_program_select, .port_a_select_n, .port_a_direction, .port_a_enable,
    .port_a_mail_select, .port_b_mail_select, .port_b_select_n, .port_b_direction,
    .port_b_enable, .port_b_data_out, .full_or_in_ready, .empty_or_out_ready,
    .almost_empty_n, .almost_full_n, .mail_one_flag, .mail_two_flag);

// file: tb/sfr_b_host.sv
// Purpose: port b host that pops the fifo and uses both mailboxes
// Assumes: the bench raises one request at a time, just after a clock edge
// Notes:   fifo reads are gated by the ready flag, so an empty fifo is never popped
`timescale 1ns/1ps

module sfr_b_host (
    input  wire rd_go,       // fifo read request
    input  wire mb_go,       // mailbox one read request
    input  wire wr_go,       // mailbox two write request
    input  wire ready,       // empty / out ready flag
    output wire select_n,    // port b chip select
    output wire direction,   // high read, low write
    output wire enable,      // port b enable
    output wire mail_select  // port b mailbox select
);
    // controls follow the request for as long as the bench holds it
    assign select_n    = ~(rd_go | mb_go | wr_go);
    assign direction   = ~wr_go;
    assign enable      = (rd_go & ready) | mb_go | wr_go;
    assign mail_select = mb_go | wr_go;
endmodule

// file: tb/sync_fifo_reset_flag_control_test.sv
// Purpose: writes on port a, reads on port b, checks order, flags and resets
// Assumes: one clock for both ports; inputs change by non-blocking assignment
// Notes:   reset pins lag by two sync flops, so ready is polled under a bound
`timescale 1ns/1ps
`include "sfr_regs.vh"

module sync_fifo_reset_flag_control_test;
    logic        clock = 0, sys_rst = 1, mr_n = 0, pf_n = 1, ets = 1, fs_lo = 1, fs_hi = 1;
    logic        a_sel_n = 1, a_en = 0, a_mb = 0, b_rd = 0, b_mb = 0, b_wr = 0;
    logic [35:0] a_din = 36'h0;
    logic [1:0]  ws = 2'h0;
    wire  [35:0] b_dout;
    wire         ir, orr, ae_n, af_n, mf1, mf2, bsn, bdir, ben, bmb;
    integer      err_total = 0, cmp_count = 0, cyc = 0, j;

    // 20 MHz clock
    always #25 clock = ~clock;

    sfr_top dut_u (.clock(clock), .sys_rst(sys_rst), .master_reset_first_n(mr_n),
        .master_reset_second_n(1'h1), .partial_flush_n(pf_n), .endian_timing_select(ets),
        .offset_select_lo(fs_lo), .offset_select_hi(fs_hi), .serial_program_select(1'h1),
        .serial_offset_in(1'h0), .port_b_width_sel(ws), .port_a_select_n(a_sel_n),
        .port_a_direction(1'h1), .port_a_enable(a_en), .port_a_mail_select(a_mb),
        .port_a_data_in(a_din), .port_a_data_out(), .port_a_data_oe(),
        .port_b_select_n(bsn), .port_b_direction(bdir), .port_b_enable(ben),
        .port_b_mail_select(bmb), .port_b_data_in(36'h00000ABCD), .port_b_data_out(b_dout),
        .port_b_data_oe(), .full_or_in_ready(ir), .empty_or_out_ready(orr),
        .almost_empty_n(ae_n), .almost_full_n(af_n), .mail_one_flag(mf1), .mail_two_flag(mf2));
    sfr_b_host host_u (.rd_go(b_rd), .mb_go(b_mb), .wr_go(b_wr), .ready(orr),
        .select_n(bsn), .direction(bdir), .enable(ben), .mail_select(bmb));

    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string name, input [35:0] seen, input [35:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one port a transfer, held until the edge that takes it
    task wr_a(input mb, input [35:0] d);
        @(posedge clock);
        a_sel_n <= 1'h0;
        a_en <= 1'h1;
        a_mb <= mb;
        a_din <= d;
        @(posedge clock);
        a_en <= 1'h0;
        a_sel_n <= 1'h1;
    endtask
    // one port b read, data looked at once the taking edge has landed
    task rd_b(input mb, input [35:0] exp);
        @(posedge clock);
        b_rd <= !mb;
        b_mb <= mb;
        @(posedge clock);
        b_rd <= 1'h0;
        b_mb <= 1'h0;
        #1 chk("port_b_data_out", b_dout, exp);
    endtask
    task wait_ir;
        for (int k = 0; k < 12 && ir !== 1'h1; k = k + 1) begin
            @(posedge clock);
            #1;
        end
        chk("full_or_in_ready", ir, 1'h1);
    endtask
    task mrst(input e, input [1:0] fs, input [1:0] w);
        @(posedge clock);
        mr_n <= 1'h0;
        ets <= e;
        {fs_hi, fs_lo} <= fs;
        ws <= w;
        repeat (6) @(posedge clock);
        mr_n <= 1'h1;
        wait_ir;
    endtask

    // hang guard: the whole run needs about 2200 cycles
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'h0;
        mrst(1'h1, 2'h3, `SFR_WS_18);
        chk("empty_or_out_ready", orr, 1'h0);
        wr_a(1'h0, 36'h123456789);
        wr_a(1'h0, 36'hFFFF00001);
        repeat (3) @(posedge clock);
        #1 chk("port_b_data_out", b_dout, 36'h0);
        chk("empty_or_out_ready", orr, 1'h1);
        rd_b(1'h0, 36'h0000048D1);
        rd_b(1'h0, 36'h000016789);
        rd_b(1'h0, 36'h00003FFFC);
        rd_b(1'h0, 36'h000000001);
        wr_a(1'h1, 36'hFFFFFFFFF);
        @(posedge clock);
        #1 chk("mail_one_flag", mf1, 1'h0);
        rd_b(1'h1, 36'h00003FFFF);
        @(posedge clock);
        #1 chk("mail_one_flag", mf1, 1'h1);
        @(posedge clock);
        b_wr <= 1'h1;
        @(posedge clock);
        b_wr <= 1'h0;
        @(posedge clock);
        #1 chk("mail_two_flag", mf2, 1'h0);
        $display("test standard big endian done");
        // fill until refused; almost full once 64 places are left
        for (j = 0; j < 1024; j = j + 1) begin
            wr_a(1'h0, j);
            if (j > 957) begin
                @(posedge clock);
                #1 chk("almost_full_n", af_n, j == 958);
            end
        end
        chk("full_or_in_ready", ir, 1'h0);
        chk("almost_empty_n", ae_n, 1'h1);
        $display("test fill done");
        // flush keeps width, endian and mode
        @(posedge clock);
        {pf_n, ets} <= 2'h0;
        repeat (6) @(posedge clock);
        pf_n <= 1'h1;
        wait_ir;
        chk("empty_or_out_ready", orr, 1'h0);
        chk("almost_full_n", af_n, 1'h1);
        wr_a(1'h0, 36'h123456789);
        repeat (2) @(posedge clock);
        rd_b(1'h0, 36'h0000048D1);
        $display("test partial flush done");
        // fall-through, little endian, 9-bit pieces
        mrst(1'h0, 2'h1, `SFR_WS_9);
        wr_a(1'h0, 36'h123456789);
        repeat (3) @(posedge clock);
        #1 chk("port_b_data_out", b_dout, 36'h000000189);
        chk("empty_or_out_ready", orr, 1'h1);
        rd_b(1'h0, 36'h0000000B3);
        rd_b(1'h0, 36'h0000000D1);
        rd_b(1'h0, 36'h000000024);
        $display("test fall through little endian done");
        end_of_test;
    end
endmodule
